// File: include/irq_ctrl_pkg.sv
/*
 * Shared constants and types for the priority and vector interrupt controller:
 * vector slot addresses, register offsets and fields, reset values, carriers.
 * Assumes a 32-bit classic Wishbone register bus and one system clock.
 */
package irq_ctrl_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Sources and vector slots
	localparam int NUM_SRC = 24;
	localparam int NUM_PERIPH = 12;
	localparam int NUM_PIN = 8;
	localparam int NUM_PORTC = 4;
	localparam int VEC_W = 16;
	localparam logic [15:0] VEC_RESET = 16'h0004;
	localparam logic [15:0] VEC_EXCEPTION = 16'h0008;
	localparam logic [15:0] VEC_RESERVED = 16'h000C;
	localparam logic [15:0] VEC_FIRST = 16'h0010;
	// Slot indices, counted from the first programmable slot
	localparam int SLOT_PERIPH_LO = 0;
	localparam int SLOT_PIN7 = 8;
	localparam int SLOT_PIN0 = 15;
	localparam int SLOT_PERIPH_HI = 16;
	localparam int SLOT_PORTC3 = 20;
	localparam logic [1:0] LEVEL_OFF = 2'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Register map (byte offsets)
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_PENDING = 8'h00;
	localparam logic [7:0] OFS_PEND_SET = 8'h04;
	localparam logic [7:0] OFS_PRIO_LO = 8'h08;
	localparam logic [7:0] OFS_PRIO_HI = 8'h0C;
	localparam logic [7:0] OFS_ROUTE = 8'h10;
	localparam logic [7:0] OFS_STATE = 8'h14;
	localparam logic [7:0] OFS_EVT_STATUS = 8'h18;
	localparam logic [7:0] OFS_EVT_MASK = 8'h1C;
	// Route register fields
	localparam int ROUTE_PORT_LSB = 0;
	localparam int ROUTE_EDGE_LSB = 8;
	localparam int ROUTE_PORTC_LSB = 16;
	localparam int ROUTE_CMP_BIT = 24;
	localparam int ROUTE_DBG_BIT = 25;
	// State register fields
	localparam int STATE_GIE_BIT = 0;
	localparam int STATE_REQ_BIT = 1;
	localparam int STATE_EXC_BIT = 2;
	localparam int STATE_IDX_LSB = 8;
	localparam int STATE_VEC_LSB = 16;
	// Event bits
	localparam int EVT_W = 3;
	localparam int EVT_ACK = 0;
	localparam int EVT_EXCEPTION = 1;
	localparam int EVT_TRAP = 2;
	// Reset values
	localparam logic [47:0] RST_PRIO = 48'h0000_0000_0000;
	localparam logic [7:0] RST_PIN_CFG = 8'h00;
	localparam logic [3:0] RST_PORTC_SEL = 4'h0;
	localparam logic [EVT_W-1:0] RST_EVT = 3'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [ADDR_W-1:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_t;

	typedef struct packed {
		logic enableIrqInstr;
		logic disableIrqInstr;
		logic trapInstr;
		logic sysException;
		logic flagLoad;
		logic flagIrqEnable;
		logic returnFromIrqInstr;
		logic savedIrqEnable;
		logic cpuAck;
	} cpu_ctl_t;

	typedef struct packed {
		logic [NUM_PIN-1:0] portaMeta;
		logic [NUM_PIN-1:0] portaSafe;
		logic [NUM_PIN-1:0] portaPrev;
		logic [NUM_PIN-1:0] portdMeta;
		logic [NUM_PIN-1:0] portdSafe;
		logic [NUM_PIN-1:0] portdPrev;
		logic [NUM_PORTC-1:0] portcMeta;
		logic [NUM_PORTC-1:0] portcSafe;
		logic [NUM_PORTC-1:0] portcPrev;
		logic cmpPrev;
		logic [NUM_SRC-1:0] pending;
		logic [2*NUM_SRC-1:0] prio;
		logic [NUM_PIN-1:0] pinPortSel;
		logic [NUM_PIN-1:0] pinEdge;
		logic [NUM_PORTC-1:0] portcChannelSlotSelect;
		logic comparatorSlotSelect;
		logic debuggerSlotSelect;
		logic globalIrqEnable;
		logic irqRequest;
		logic exceptionReq;
		logic [4:0] winnerIdx;
		logic [VEC_W-1:0] vectorAddr;
		logic [23:0] handlerAddr;
		logic handlerValid;
		logic [EVT_W-1:0] evtStatus;
		logic [EVT_W-1:0] evtMask;
		logic irqOut;
		logic wbAck;
		logic [31:0] wbDatOut;
	} ctrl_state_t;

endpackage

// File: core/priority_vector_irq_controller.sv
/*
 * Interrupt priority and vector selection with global enable tracking,
 * source routing for shared slots and a Wishbone register slave.
 * Assumes port pins are asynchronous, all other inputs are on core_clk,
 * and peripheral and channel requests are one-cycle pulses.
 */
// Overview of operation
// - Programmable sources take level 3 (most urgent), 2 or 1.
// - A higher level always beats every lower level request.
// - Within one level the lowest vector slot wins.
// - Reset and system exception slots outrank all; 000Ch is reserved.
// - Programmable slots start at 0010h, four bytes apart, fixed source order.
// - Slot 0030h takes pin 7 edge or comparator both edges.
// - Slot 004Ch takes pin 0 edge or debugger request.
// - Last four slots take port C both edges or DMA completion.
// - Vector entry byte 0 ignored; bytes 1 to 3 hold handler address.
// - Global enable is flag bit 0; any flag load updates it.
// - Interrupt return restores global enable from saved flags.
// - Enable instruction or flag write of 1 sets global enable.
// - Disable, vectored acknowledge, write 0, reset, trap, exception clear global enable.
// - Comparator select 1 routes comparator to pin 7 slot, else pin.
// - Debug select 1 routes debugger to pin 0 slot, else pin.
// - Port C select 0 routes DMA channel, 1 routes port C pin.
`timescale 1ns/1ps

module priority_vector_irq_controller (
	input wire logic core_clk, // System clock
	input wire logic rst, // Asynchronous reset, active high
	input wire irq_ctrl_pkg::wb_req_t wbIn, // Wishbone request
	output logic wbAck, // Wishbone acknowledge
	output logic [31:0] wbDatOut, // Wishbone read data
	input wire logic [irq_ctrl_pkg::NUM_PERIPH-1:0] periphReq, // Peripheral request pulses
	input wire logic [irq_ctrl_pkg::NUM_PORTC-1:0] dmaDone, // DMA channel done pulses
	input wire logic [irq_ctrl_pkg::NUM_PIN-1:0] portaPin, // Port A pins
	input wire logic [irq_ctrl_pkg::NUM_PIN-1:0] portdPin, // Port D pins
	input wire logic [irq_ctrl_pkg::NUM_PORTC-1:0] portcPin, // Port C pins
	input wire logic comparatorOut, // Comparator output level
	input wire logic onChipDebuggerRequest, // Debugger request pulse
	input wire logic exceptionPending, // System exception waiting
	input wire irq_ctrl_pkg::cpu_ctl_t cpuCtl, // CPU events
	input wire logic vecFetchValid, // Vector entry fetched
	input wire logic [31:0] vecFetchWord, // Vector entry, byte 0 in [31:24]
	output logic irqRequest, // Request to CPU
	output logic [irq_ctrl_pkg::VEC_W-1:0] vectorAddr, // Vector slot address
	output logic globalIrqEnable, // Global interrupt enable
	output logic [23:0] handlerAddr, // Handler address from entry
	output logic handlerValid, // Handler address updated
	output logic irqOut // Controller event interrupt
);
	import irq_ctrl_pkg::*;

	ctrl_state_t s;
	ctrl_state_t next_s;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [5:0] pickWinner(input logic [NUM_SRC-1:0] req,
		input logic [2*NUM_SRC-1:0] lvl);
		logic found;
		logic [4:0] idx;
		found = 1'b0;
		idx = 5'h0;
		for (int l = 3; l >= 1; l--) begin
			for (int k = 0; k < NUM_SRC; k++) begin
				if (!found && req[k] && lvl[2*k +: 2] == 2'(l)) begin
					found = 1'b1;
					idx = 5'(k);
				end
			end
		end
		return {found, idx};
	endfunction

	function automatic logic [31:0] laneMask(input logic [3:0] sel);
		return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	function automatic logic [31:0] mergeBytes(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		return (old & ~laneMask(sel)) | (dat & laneMask(sel));
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Combinational next state

	logic [NUM_PIN-1:0] pinNow;
	logic [NUM_PIN-1:0] pinOld;
	logic [NUM_PIN-1:0] pinEvt;
	logic [NUM_PORTC-1:0] portcEdge;
	logic cmpEdge;
	logic [NUM_SRC-1:0] srcReq;
	logic [NUM_SRC-1:0] swSet;
	logic [NUM_SRC-1:0] swClr;
	logic [NUM_SRC-1:0] ackClr;
	logic vectoredAck;
	logic access;
	logic wr;
	logic [31:0] wMask;
	logic [31:0] route;
	logic [31:0] prioLo;
	logic [31:0] prioHi;
	logic [31:0] rdData;
	logic [EVT_W-1:0] evtSet;
	logic [EVT_W-1:0] evtClr;
	logic gie;
	logic [5:0] win;

	always_comb begin
		next_s = s;

		// Two-stage synchronisers, third stage for edges
		next_s.portaMeta = portaPin;
		next_s.portaSafe = s.portaMeta;
		next_s.portaPrev = s.portaSafe;
		next_s.portdMeta = portdPin;
		next_s.portdSafe = s.portdMeta;
		next_s.portdPrev = s.portdSafe;
		next_s.portcMeta = portcPin;
		next_s.portcSafe = s.portcMeta;
		next_s.portcPrev = s.portcSafe;
		next_s.cmpPrev = comparatorOut;

		// Port A or D per pin, chosen edge
		pinNow = (s.portdSafe & s.pinPortSel) | (s.portaSafe & ~s.pinPortSel);
		pinOld = (s.portdPrev & s.pinPortSel) | (s.portaPrev & ~s.pinPortSel);
		pinEvt = (s.pinEdge & pinNow & ~pinOld) | (~s.pinEdge & ~pinNow & pinOld);
		portcEdge = s.portcSafe ^ s.portcPrev;
		cmpEdge = comparatorOut ^ s.cmpPrev;

		srcReq = '0;
		srcReq[SLOT_PIN7-1:SLOT_PERIPH_LO] = periphReq[7:0];
		srcReq[SLOT_PORTC3-1:SLOT_PERIPH_HI] = periphReq[11:8];
		for (int p = 1; p < NUM_PIN - 1; p++) begin
			srcReq[SLOT_PIN7 + p] = pinEvt[NUM_PIN - 1 - p];
		end
		srcReq[SLOT_PIN7] = s.comparatorSlotSelect ? cmpEdge : pinEvt[NUM_PIN - 1];
		srcReq[SLOT_PIN0] = s.debuggerSlotSelect ? onChipDebuggerRequest : pinEvt[0];
		// Port C pin or DMA channel
		for (int c = 0; c < NUM_PORTC; c++) begin
			srcReq[SLOT_PORTC3 + c] = s.portcChannelSlotSelect[NUM_PORTC - 1 - c] ?
				portcEdge[NUM_PORTC - 1 - c] : dmaDone[NUM_PORTC - 1 - c];
		end

		// Wishbone decode, write commits at the edge where the master samples ack
		access = wbIn.cyc && wbIn.stb && !s.wbAck;
		wr = wbIn.cyc && wbIn.stb && wbIn.we && s.wbAck;
		wMask = laneMask(wbIn.sel);
		route = '0;
		route[ROUTE_PORT_LSB +: NUM_PIN] = s.pinPortSel;
		route[ROUTE_EDGE_LSB +: NUM_PIN] = s.pinEdge;
		route[ROUTE_PORTC_LSB +: NUM_PORTC] = s.portcChannelSlotSelect;
		route[ROUTE_CMP_BIT] = s.comparatorSlotSelect;
		route[ROUTE_DBG_BIT] = s.debuggerSlotSelect;
		prioLo = s.prio[31:0];
		prioHi = {16'h0000, s.prio[47:32]};
		swSet = '0;
		swClr = '0;
		evtClr = '0;
		if (wr) begin
			unique case (wbIn.adr)
				OFS_PENDING: swClr = wbIn.dat[NUM_SRC-1:0] & wMask[NUM_SRC-1:0];
				OFS_PEND_SET: swSet = wbIn.dat[NUM_SRC-1:0] & wMask[NUM_SRC-1:0];
				OFS_PRIO_LO: next_s.prio[31:0] = mergeBytes(prioLo, wbIn.dat, wbIn.sel);
				OFS_PRIO_HI: begin
					prioHi = mergeBytes(prioHi, wbIn.dat, wbIn.sel);
					next_s.prio[47:32] = prioHi[15:0];
				end
				OFS_ROUTE: begin
					route = mergeBytes(route, wbIn.dat, wbIn.sel);
					next_s.pinPortSel = route[ROUTE_PORT_LSB +: NUM_PIN];
					next_s.pinEdge = route[ROUTE_EDGE_LSB +: NUM_PIN];
					next_s.portcChannelSlotSelect = route[ROUTE_PORTC_LSB +: NUM_PORTC];
					next_s.comparatorSlotSelect = route[ROUTE_CMP_BIT];
					next_s.debuggerSlotSelect = route[ROUTE_DBG_BIT];
				end
				OFS_EVT_STATUS: evtClr = wbIn.dat[EVT_W-1:0] & wMask[EVT_W-1:0];
				OFS_EVT_MASK: next_s.evtMask = (s.evtMask & ~wMask[EVT_W-1:0]) |
					(wbIn.dat[EVT_W-1:0] & wMask[EVT_W-1:0]);
				default: ;
			endcase
		end

		rdData = 32'h0000_0000;
		unique case (wbIn.adr)
			OFS_PENDING: rdData[NUM_SRC-1:0] = s.pending;
			OFS_PRIO_LO: rdData = prioLo;
			OFS_PRIO_HI: rdData = {16'h0000, s.prio[47:32]};
			OFS_ROUTE: begin
				rdData[ROUTE_PORT_LSB +: NUM_PIN] = s.pinPortSel;
				rdData[ROUTE_EDGE_LSB +: NUM_PIN] = s.pinEdge;
				rdData[ROUTE_PORTC_LSB +: NUM_PORTC] = s.portcChannelSlotSelect;
				rdData[ROUTE_CMP_BIT] = s.comparatorSlotSelect;
				rdData[ROUTE_DBG_BIT] = s.debuggerSlotSelect;
			end
			OFS_STATE: begin
				rdData[STATE_GIE_BIT] = s.globalIrqEnable;
				rdData[STATE_REQ_BIT] = s.irqRequest;
				rdData[STATE_EXC_BIT] = s.exceptionReq;
				rdData[STATE_IDX_LSB +: 5] = s.winnerIdx;
				rdData[STATE_VEC_LSB +: VEC_W] = s.vectorAddr;
			end
			OFS_EVT_STATUS: rdData[EVT_W-1:0] = s.evtStatus;
			OFS_EVT_MASK: rdData[EVT_W-1:0] = s.evtMask;
			default: ;
		endcase
		next_s.wbAck = access;
		next_s.wbDatOut = access ? rdData : 32'h0000_0000;

		// Acknowledge of a presented vectored request
		vectoredAck = cpuCtl.cpuAck && s.irqRequest && !s.exceptionReq;
		ackClr = '0;
		if (vectoredAck) begin
			ackClr[s.winnerIdx] = 1'b1;
		end
		// New requests win over any clear in the same cycle
		next_s.pending = (s.pending & ~ackClr & ~swClr) | srcReq | swSet;

		// Global enable, later lines take precedence
		gie = s.globalIrqEnable;
		if (cpuCtl.enableIrqInstr) begin
			gie = 1'b1;
		end
		if (cpuCtl.disableIrqInstr) begin
			gie = 1'b0;
		end
		if (cpuCtl.flagLoad) begin
			gie = cpuCtl.flagIrqEnable;
		end
		if (cpuCtl.returnFromIrqInstr) begin
			gie = cpuCtl.savedIrqEnable;
		end
		if (vectoredAck || cpuCtl.trapInstr || cpuCtl.sysException) begin
			gie = 1'b0;
		end
		next_s.globalIrqEnable = gie;

		// Level 0 means not taking part
		win = pickWinner(next_s.pending, next_s.prio);
		next_s.exceptionReq = exceptionPending;
		next_s.winnerIdx = win[4:0];
		if (exceptionPending) begin
			next_s.irqRequest = 1'b1;
			next_s.vectorAddr = VEC_EXCEPTION;
		end else if (gie && win[5]) begin
			next_s.irqRequest = 1'b1;
			next_s.vectorAddr = VEC_FIRST + {9'h000, win[4:0], 2'b00};
		end else begin
			next_s.irqRequest = 1'b0;
		end

		// Byte 0 dropped, bytes 1 to 3 upper to lower
		next_s.handlerValid = vecFetchValid;
		if (vecFetchValid) begin
			next_s.handlerAddr = vecFetchWord[23:0];
		end

		// Sticky events, set wins over write-one clear
		evtSet = '0;
		evtSet[EVT_ACK] = vectoredAck;
		evtSet[EVT_EXCEPTION] = cpuCtl.sysException;
		evtSet[EVT_TRAP] = cpuCtl.trapInstr;
		next_s.evtStatus = (s.evtStatus & ~evtClr) | evtSet;
		next_s.irqOut = |(next_s.evtStatus & next_s.evtMask);
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.prio <= RST_PRIO;
			s.pinPortSel <= RST_PIN_CFG;
			s.pinEdge <= RST_PIN_CFG;
			s.portcChannelSlotSelect <= RST_PORTC_SEL;
			s.vectorAddr <= VEC_RESET;
			s.evtMask <= RST_EVT;
			s.evtStatus <= RST_EVT;
		end else begin
			s <= next_s;
		end
	end

	assign wbAck = s.wbAck;
	assign wbDatOut = s.wbDatOut;
	assign irqRequest = s.irqRequest;
	assign vectorAddr = s.vectorAddr;
	assign globalIrqEnable = s.globalIrqEnable;
	assign handlerAddr = s.handlerAddr;
	assign handlerValid = s.handlerValid;
	assign irqOut = s.irqOut;

endmodule // priority_vector_irq_controller

// File: verification/irq_ctrl_properties.sv
/* Concurrent checks on the interrupt controller ports.
   Assumes binding onto the top module, one clock domain. */
`timescale 1ns/1ps
module irq_ctrl_properties (
	input wire logic core_clk, // Clock
	input wire logic rst, // Reset
	input wire logic exceptionPending, // Exception waiting
	input wire irq_ctrl_pkg::cpu_ctl_t cpuCtl, // CPU events
	input wire logic vecFetchValid, // Entry fetched
	input wire logic [31:0] vecFetchWord, // Entry word
	input wire logic irqRequest, // Request to CPU
	input wire logic [irq_ctrl_pkg::VEC_W-1:0] vectorAddr, // Slot
	input wire logic globalIrqEnable, // Global enable
	input wire logic [23:0] handlerAddr, // Handler
	input wire logic handlerValid // Handler strobe
);
	import irq_ctrl_pkg::*;
	logic lateClr;
	assign lateClr = cpuCtl.trapInstr | cpuCtl.sysException | cpuCtl.cpuAck;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////
	property p_excVector;
		exceptionPending |=> irqRequest && vectorAddr == VEC_EXCEPTION;
	endproperty
	a_excVector: assert property (p_excVector) else $error("no exception slot");
	property p_slotRange;
		irqRequest |-> vectorAddr[1:0] == 2'h0 && vectorAddr >= VEC_EXCEPTION
			&& vectorAddr <= 16'h006C && vectorAddr != VEC_RESERVED;
	endproperty
	a_slotRange: assert property (p_slotRange) else $error("bad slot");
	property p_gateByEnable;
		irqRequest && vectorAddr != VEC_EXCEPTION |-> globalIrqEnable;
	endproperty
	a_gateByEnable: assert property (p_gateByEnable) else $error("request while off");
	property p_ackClears;
		cpuCtl.cpuAck && irqRequest && vectorAddr != VEC_EXCEPTION |=> !globalIrqEnable;
	endproperty
	a_ackClears: assert property (p_ackClears) else $error("ack kept enable");
	property p_trapClears;
		cpuCtl.trapInstr || cpuCtl.sysException |=> !globalIrqEnable;
	endproperty
	a_trapClears: assert property (p_trapClears) else $error("trap kept enable");
	property p_enableInstr;
		cpuCtl.enableIrqInstr && !cpuCtl.disableIrqInstr && !cpuCtl.flagLoad
			&& !cpuCtl.returnFromIrqInstr && !lateClr |=> globalIrqEnable;
	endproperty
	a_enableInstr: assert property (p_enableInstr) else $error("enable missed");
	property p_flagLoad;
		cpuCtl.flagLoad && !cpuCtl.returnFromIrqInstr && !lateClr
			|=> globalIrqEnable == $past(cpuCtl.flagIrqEnable);
	endproperty
	a_flagLoad: assert property (p_flagLoad) else $error("flag load missed");
	property p_irqReturn;
		cpuCtl.returnFromIrqInstr && !lateClr
			|=> globalIrqEnable == $past(cpuCtl.savedIrqEnable);
	endproperty
	a_irqReturn: assert property (p_irqReturn) else $error("return restore missed");
	property p_handler;
		vecFetchValid |=> handlerValid && handlerAddr == $past(vecFetchWord[23:0]);
	endproperty
	a_handler: assert property (p_handler) else $error("handler address wrong");
endmodule // irq_ctrl_properties

bind priority_vector_irq_controller irq_ctrl_properties u_irq_ctrl_properties (.core_clk,
	.rst, .exceptionPending, .cpuCtl, .vecFetchValid, .vecFetchWord, .irqRequest,
	.vectorAddr, .globalIrqEnable, .handlerAddr, .handlerValid);

// File: verification/cpu_model.sv
/* Processor core stand-in: acknowledges requests, fetches vector entries.
   Assumes registered controller outputs on the same clock. */
`timescale 1ns/1ps
module cpu_model (
	input wire logic core_clk, // Clock
	input wire logic rst, // Reset
	input wire logic autoAck, // Answer requests
	input wire logic irqRequest, // Request seen
	input wire logic [irq_ctrl_pkg::VEC_W-1:0] vectorAddr, // Slot
	output logic cpuAck, // Ack pulse
	output logic vecFetchValid, // Entry strobe
	output logic [31:0] vecFetchWord // Entry word
);
	import irq_ctrl_pkg::*;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cpuAck <= 1'h0;
			vecFetchValid <= 1'h0;
			vecFetchWord <= 32'h0000_0000;
		end else begin
			cpuAck <= autoAck && irqRequest && !cpuAck && !vecFetchValid;
			vecFetchValid <= cpuAck;
			vecFetchWord <= cpuAck ? {8'hFF, 8'h5A, vectorAddr} : ~vecFetchWord;
		end
	end
endmodule // cpu_model

// File: verification/tb.sv
/* Self-checking bench for the interrupt controller.
   Assumes the package, the design, its checker and the core model. */
`timescale 1ns/1ps
module tb;
	import irq_ctrl_pkg::*;
	logic core_clk = 1'h0;
	logic rst = 1'h1;
	wb_req_t wbIn = '0;
	cpu_ctl_t ctl = '0;
	logic [11:0] periphReq = 12'h000;
	logic [3:0] dmaDone = 4'h0, portcPin = 4'h0;
	logic [7:0] portaPin = 8'h00, portdPin = 8'h00;
	logic comparatorOut = 1'h0, onChipDebuggerRequest = 1'h0;
	logic exceptionPending = 1'h0, autoAck = 1'h1;
	logic wbAck, irqRequest, globalIrqEnable, handlerValid, irqOut, cpuAck, vecFetchValid;
	logic [31:0] wbDatOut, vecFetchWord, rd;
	logic [15:0] vectorAddr;
	logic [23:0] handlerAddr;
	int bad_count = 0;
	int n_tests = 0;
	logic [8:0] ev [10] = '{9'h100, 9'h080, 9'h018, 9'h010, 9'h006, 9'h004, 9'h100,
		9'h040, 9'h100, 9'h020};
	priority_vector_irq_controller u_priority_vector_irq_controller (.core_clk, .rst,
		.wbIn, .wbAck, .wbDatOut, .periphReq, .dmaDone, .portaPin, .portdPin, .portcPin,
		.comparatorOut, .onChipDebuggerRequest, .exceptionPending,
		.cpuCtl(cpu_ctl_t'(ctl | {8'h00, cpuAck})), .vecFetchValid, .vecFetchWord,
		.irqRequest, .vectorAddr, .globalIrqEnable, .handlerAddr, .handlerValid, .irqOut);
	cpu_model u_cpu_model (.core_clk, .rst, .autoAck, .irqRequest, .vectorAddr, .cpuAck,
		.vecFetchValid, .vecFetchWord);
	initial forever #12.5 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		wbIn <= '{1'h1, 1'h1, w, a, 4'hF, d};
		do begin
			@(posedge core_clk);
		end while (wbAck !== 1'h1);
		rd = wbDatOut;
		wbIn <= '0;
	endtask
	task automatic pulse(input logic [8:0] v);
		@(posedge core_clk);
		ctl <= cpu_ctl_t'(v);
		@(posedge core_clk);
		ctl <= '0;
		@(posedge core_clk);
	endtask
	task automatic expectVec(input int idx);
		logic [15:0] v;
		v = VEC_FIRST + 16'(4 * idx);
		pulse(9'h100);
		while (irqRequest !== 1'h1) begin
			@(posedge core_clk);
		end
		chk(32'(vectorAddr), 32'(v));
		while (handlerValid !== 1'h1) begin
			@(posedge core_clk);
		end
		chk(32'(handlerAddr), {8'h00, 8'h5A, v});
		chk(32'(globalIrqEnable), 32'h0);
	endtask
	task automatic srcPulse(input logic [11:0] p, input logic [3:0] d);
		@(posedge core_clk);
		periphReq <= p;
		dmaDone <= d;
		@(posedge core_clk);
		periphReq <= 12'h000;
		dmaDone <= 4'h0;
	endtask
	task automatic final_report();
		if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge core_clk);
		chk(32'(vectorAddr), 32'(VEC_RESET));
		chk(32'(globalIrqEnable), 32'h0);
		repeat (2) @(posedge core_clk);
		rst <= 1'h0;
		for (int i = 0; i < 10; i++) begin
			pulse(ev[i]);
			chk(32'(globalIrqEnable), 32'(i % 2 == 0));
		end
		wb(1'h1, OFS_EVT_MASK, 32'h0000_0004);
		@(posedge core_clk);
		chk(32'(irqOut), 32'h1);
		wb(1'h1, OFS_EVT_STATUS, 32'h0000_0004);
		wb(1'h0, OFS_EVT_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0002);
		chk(32'(irqOut), 32'h0);
		wb(1'h0, 8'h20, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		wb(1'h1, OFS_PRIO_LO, 32'hAAAA_AAAA);
		wb(1'h1, OFS_PRIO_HI, 32'h0000_AAAA);
		srcPulse(12'hFFF, 4'hF);
		wb(1'h0, OFS_PENDING, 32'h0000_0000);
		chk(rd, 32'h00FF_00FF);
		for (int k = 0; k < 16; k++) expectVec(k < 8 ? k : k + 8);
		wb(1'h1, OFS_PRIO_LO, 32'h0000_0801);
		wb(1'h1, OFS_PRIO_HI, 32'h0000_C000);
		srcPulse(12'h021, 4'h1);
		expectVec(23);
		expectVec(5);
		expectVec(0);
		wb(1'h1, OFS_PRIO_LO, 32'h0000_000C);
		wb(1'h1, OFS_PEND_SET, 32'h0000_0002);
		repeat (3) @(posedge core_clk);
		chk(32'(irqRequest), 32'h0);
		autoAck <= 1'h0;
		exceptionPending <= 1'h1;
		pulse(9'h100);
		chk(32'(vectorAddr), 32'(VEC_EXCEPTION));
		chk(32'(irqRequest), 32'h1);
		pulse(9'h020);
		exceptionPending <= 1'h0;
		// Let the exception request drop before the core answers again
		@(posedge core_clk);
		autoAck <= 1'h1;
		expectVec(1);
		wb(1'h1, OFS_PRIO_LO, 32'hC003_0000);
		wb(1'h1, OFS_ROUTE, 32'h0301_0000);
		comparatorOut <= 1'h1;
		expectVec(8);
		comparatorOut <= 1'h0;
		expectVec(8);
		onChipDebuggerRequest <= 1'h1;
		@(posedge core_clk);
		onChipDebuggerRequest <= 1'h0;
		expectVec(15);
		portcPin <= 4'h1;
		expectVec(23);
		wb(1'h1, OFS_ROUTE, 32'h0000_0101);
		portdPin <= 8'h01;
		expectVec(15);
		// Port A pin 7, falling edge select: rise is ignored, fall requests
		wb(1'h1, OFS_ROUTE, 32'h0000_0000);
		portaPin <= 8'h80;
		repeat (5) @(posedge core_clk);
		chk(32'(irqRequest), 32'h0);
		portaPin <= 8'h00;
		expectVec(8);
		final_report();
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		bad_count++;
		final_report();
	end
endmodule // tb
